// >>> hw/scan_timing_pkg.sv
// Package for the scan and conversion timing engine: register offsets,
// field positions, reset values, timing counts and shared structs.
// Assumes a 200 MHz system clock and a 32-bit plain register port.
package scan_timing_pkg;

    // Clock and timebases
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TB_FAST_HZ = 20_000_000;
    localparam int TB_SLOW_HZ = 100_000;
    localparam logic [10:0] TB_FAST_DIV = 11'(CLK_HZ / TB_FAST_HZ);
    localparam logic [10:0] TB_SLOW_DIV = 11'(CLK_HZ / TB_SLOW_HZ);

    // Output pulse width, least figure rounded up to whole cycles
    localparam int PULSE_MIN_NS = 50;
    localparam logic [3:0] PULSE_CYC =
        4'((PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Delay from last conversion to scan-in-progress fall
    localparam int SCAN_OFF_NS = 50;
    localparam logic [3:0] SCAN_OFF_CYC =
        4'((SCAN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Pin numbers of the dedicated outputs
    localparam int NUM_PINS = 10;
    localparam int PIN_CONVERT = 2;
    localparam int PIN_SCAN_START = 7;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ROUTE = 8'h04;
    localparam logic [7:0] OFF_TRIG_ROUTE = 8'h08;
    localparam logic [7:0] OFF_SCAN_INTERVAL = 8'h0C;
    localparam logic [7:0] OFF_SAMPLE_INTERVAL = 8'h10;
    localparam logic [7:0] OFF_SCAN_TOTAL = 8'h14;
    localparam logic [7:0] OFF_CONV_PER_SCAN = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [7:0] OFF_COMMAND = 8'h20;

    // Control register fields
    localparam int CTRL_SW_GATE = 0;
    localparam int CTRL_SCAN_EXT = 1;
    localparam int CTRL_CONV_EXT = 2;
    localparam int CTRL_SICLK_EXT = 3;
    localparam int CTRL_TB_SLOW = 4;
    localparam int CTRL_SCAN_LEVEL_MODE = 5;
    localparam int CTRL_SCAN_PIN_OE = 6;
    localparam int CTRL_CONV_PIN_OE = 7;
    localparam int CTRL_WIDTH = 8;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Route register fields: 8 bits per routed input
    localparam int ROUTE_SCAN_LSB = 0;
    localparam int ROUTE_CONV_LSB = 8;
    localparam int ROUTE_GATE_LSB = 16;
    localparam int ROUTE_SICLK_LSB = 24;
    localparam int ROUTE_SEL_W = 4;
    localparam int ROUTE_POL_BIT = 4;
    localparam int ROUTE_EDGE_BIT = 5;

    // Command register fields (write-only pulses)
    localparam int CMD_TRIGGER = 0;
    localparam int CMD_STOP = 1;

    // Status register fields
    localparam int STAT_ACQ = 0;
    localparam int STAT_SCAN = 1;
    localparam int STAT_GATED = 2;
    localparam int STAT_DONE_LSB = 8;

    // Counter reset values
    localparam logic [23:0] SCAN_INTERVAL_RESET = 24'h0000FF;
    localparam logic [15:0] SAMPLE_INTERVAL_RESET = 16'h000F;
    localparam logic [23:0] SCAN_TOTAL_RESET = 24'h000000;
    localparam logic [7:0] CONV_PER_SCAN_RESET = 8'h01;

    // Routing of one function-pin input
    typedef struct packed {
        logic edge_mode;
        logic active_low;
        logic [3:0] sel;
    } pin_route_s;

    // Conditioned input: active level and one-cycle active edge
    typedef struct packed {
        logic level;
        logic edge_hit;
    } pin_event_s;

endpackage

// >>> hw/function_pin_input.sv
// Selects one programmable function pin, synchronises it and reports
// its active level and active edge. Pins are asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module function_pin_input (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Pins and routing
    input wire logic [scan_timing_pkg::NUM_PINS-1:0] pins_in,
    input wire scan_timing_pkg::pin_route_s route_in,
    // Conditioned result
    output scan_timing_pkg::pin_event_s event_out
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } cond_state_s;

    cond_state_s s;
    cond_state_s next_s;
    logic picked;
    logic active;

    // Mux ahead of the synchroniser; a route change may give one glitch
    always_comb begin
        picked = 1'b0;
        if (32'(route_in.sel) < scan_timing_pkg::NUM_PINS) begin
            picked = pins_in[route_in.sel];
        end
        next_s = s;
        next_s.meta = picked;
        next_s.sync = s.meta;
        next_s.prev = s.sync ^ route_in.active_low;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign active = s.sync ^ route_in.active_low;
    assign event_out.level = active;
    assign event_out.edge_hit = active & ~s.prev;

endmodule
`default_nettype wire

// >>> hw/scan_convert_timing_control.sv
// Scan-start and conversion timing engine for the analog input: scan
// interval counter, sample interval counter, gating and pin outputs.
// Assumes pins are asynchronous, a 200 MHz clock and a register port
// with read data one cycle after the read strobe.
//
// Functional notes
// - Scan start comes from any function pin, edge detected, chosen polarity.
// - Each selected active scan-start edge begins a scan.
// - With internal pacing the sample interval counter starts at scan start.
// - Scan-start output mirrors the real start pulse, whatever its source.
// - Output option one: active-high pulse of 50 to 100 ns at scan start.
// - Option two: high during scan, falls fixed delay after last conversion.
// - Function pin outputs stay undriven after startup until software enables.
// - No conversion strobes before a scan start has been made.
// - First conversion at sample count zero, or first external strobe.
// - Scan interval counter makes starts; trigger starts, software or count stops.
// - Scan starts and strobes outside an acquisition are ignored.
// - Scans may be gated by the gate input or a software gate bit.
// - Conversion strobe from any pin, chosen edge starts one conversion.
// - Convert output mirrors real convert pulse, active low, 50 to 100 ns.
// - Sample counter runs and reloads during scan, reloads again at end.
// - Gate from any pin, either polarity, level or edge mode.
// - Level mode blocks while active; edge mode toggles disable and enable.
// - Gate acts only at next scan start, never cuts or resumes a scan.
// - Scan counter clocked by external input active edge or 20 MHz / 100 kHz.
// - Selected acquisition trigger edge starts the acquisition sequence.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scan_convert_timing_control (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [31:0] rdata_out,
    // Programmable function pins (two-way)
    input wire logic [scan_timing_pkg::NUM_PINS-1:0] programmable_function_pin_in,
    output logic [scan_timing_pkg::NUM_PINS-1:0] programmable_function_pin_out,
    output logic [scan_timing_pkg::NUM_PINS-1:0] programmable_function_pin_oe_out,
    // Converter side and status
    output logic adc_convert_out,
    output logic acquisition_active_out,
    output logic scan_active_out
);

    typedef struct packed {
        logic [7:0] ctrl;
        logic [31:0] route;
        scan_timing_pkg::pin_route_s trig_route;
        logic [23:0] scan_interval;
        logic [15:0] sample_interval;
        logic [23:0] scan_total;
        logic [7:0] conv_per_scan;
        logic [10:0] tb_cnt;
        logic acq;
        logic scan;
        logic gate_toggle;
        logic [23:0] si_cnt;
        logic [15:0] samp_cnt;
        logic [7:0] conv_left;
        logic [23:0] scans_done;
        logic [3:0] scan_pulse_cnt;
        logic [3:0] conv_pulse_cnt;
        logic [3:0] off_cnt;
        logic scan_level;
        logic convert;
        logic [31:0] rdata;
    } engine_state_s;

    engine_state_s s;
    engine_state_s next_s;

    scan_timing_pkg::pin_event_s scan_ev;
    scan_timing_pkg::pin_event_s conv_ev;
    scan_timing_pkg::pin_event_s gate_ev;
    scan_timing_pkg::pin_event_s siclk_ev;
    scan_timing_pkg::pin_event_s trig_ev;

    logic tb_tick;
    logic si_tick;
    logic sw_trigger;
    logic sw_stop;
    logic gated_off;
    logic scan_req;
    logic start_ok;
    logic conv_fire;
    logic last_conv;
    logic [23:0] done_inc;

    // Down counter with reload at zero
    function automatic logic [23:0] count_next(input logic [23:0] cnt,
                                               input logic [23:0] load);
        if (cnt == 24'h000000) begin
            count_next = load;
        end else begin
            count_next = cnt - 24'h000001;
        end
    endfunction

    // Extract one routed input's fields from the route register
    function automatic scan_timing_pkg::pin_route_s route_of(input logic [31:0] r,
                                                               input int lsb);
        route_of.sel = r[lsb +: scan_timing_pkg::ROUTE_SEL_W];
        route_of.active_low = r[lsb + scan_timing_pkg::ROUTE_POL_BIT];
        route_of.edge_mode = r[lsb + scan_timing_pkg::ROUTE_EDGE_BIT];
    endfunction

    function_pin_input u_scan_in (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pins_in(programmable_function_pin_in),
        .route_in(route_of(s.route, scan_timing_pkg::ROUTE_SCAN_LSB)),
        .event_out(scan_ev)
    );

    function_pin_input u_conv_in (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pins_in(programmable_function_pin_in),
        .route_in(route_of(s.route, scan_timing_pkg::ROUTE_CONV_LSB)),
        .event_out(conv_ev)
    );

    function_pin_input u_gate_in (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pins_in(programmable_function_pin_in),
        .route_in(route_of(s.route, scan_timing_pkg::ROUTE_GATE_LSB)),
        .event_out(gate_ev)
    );

    function_pin_input u_siclk_in (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pins_in(programmable_function_pin_in),
        .route_in(route_of(s.route, scan_timing_pkg::ROUTE_SICLK_LSB)),
        .event_out(siclk_ev)
    );

    function_pin_input u_trig_in (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pins_in(programmable_function_pin_in),
        .route_in(s.trig_route),
        .event_out(trig_ev)
    );

    // Software command pulses
    assign sw_trigger = write_in && (addr_in == scan_timing_pkg::OFF_COMMAND)
        && wdata_in[scan_timing_pkg::CMD_TRIGGER];
    assign sw_stop = write_in && (addr_in == scan_timing_pkg::OFF_COMMAND)
        && wdata_in[scan_timing_pkg::CMD_STOP];

    // internal timebase tick or external clock active edge
    assign tb_tick = (s.tb_cnt == 11'h000);
    assign si_tick = s.ctrl[scan_timing_pkg::CTRL_SICLK_EXT] ? siclk_ev.edge_hit : tb_tick;

    // gate state, level or toggled by edges
    assign gated_off = s.ctrl[scan_timing_pkg::CTRL_SW_GATE]
        | (route_of(s.route, scan_timing_pkg::ROUTE_GATE_LSB).edge_mode
           ? s.gate_toggle : gate_ev.level);

    // scan request from the chosen source
    assign scan_req = s.ctrl[scan_timing_pkg::CTRL_SCAN_EXT]
        ? scan_ev.edge_hit
        : (si_tick && (s.si_cnt == 24'h000000));

    // start accepted only inside acquisition, gate checked at start
    assign start_ok = s.acq && scan_req && !s.scan && !gated_off;

    // conversions only inside a running scan
    assign conv_fire = s.scan && (s.ctrl[scan_timing_pkg::CTRL_CONV_EXT]
        ? conv_ev.edge_hit
        : (tb_tick && (s.samp_cnt == 16'h0000)));
    assign last_conv = conv_fire && (s.conv_left <= 8'h01);
    assign done_inc = s.scans_done + 24'h000001;

    // Next-state logic for the whole engine
    always_comb begin
        next_s = s;
        next_s.convert = 1'b0;

        // Register writes
        if (write_in) begin
            if (addr_in == scan_timing_pkg::OFF_CTRL) begin
                next_s.ctrl = wdata_in[scan_timing_pkg::CTRL_WIDTH-1:0];
            end else if (addr_in == scan_timing_pkg::OFF_ROUTE) begin
                next_s.route = wdata_in;
            end else if (addr_in == scan_timing_pkg::OFF_TRIG_ROUTE) begin
                next_s.trig_route = wdata_in[5:0];
            end else if (addr_in == scan_timing_pkg::OFF_SCAN_INTERVAL) begin
                next_s.scan_interval = wdata_in[23:0];
            end else if (addr_in == scan_timing_pkg::OFF_SAMPLE_INTERVAL) begin
                next_s.sample_interval = wdata_in[15:0];
            end else if (addr_in == scan_timing_pkg::OFF_SCAN_TOTAL) begin
                next_s.scan_total = wdata_in[23:0];
            end else if (addr_in == scan_timing_pkg::OFF_CONV_PER_SCAN) begin
                next_s.conv_per_scan = wdata_in[7:0];
            end
        end

        // Register reads, answered in the next cycle; unmapped reads zero
        next_s.rdata = 32'h00000000;
        if (read_in) begin
            if (addr_in == scan_timing_pkg::OFF_CTRL) begin
                next_s.rdata = {24'h000000, s.ctrl};
            end else if (addr_in == scan_timing_pkg::OFF_ROUTE) begin
                next_s.rdata = s.route;
            end else if (addr_in == scan_timing_pkg::OFF_TRIG_ROUTE) begin
                next_s.rdata = {26'h0000000, s.trig_route};
            end else if (addr_in == scan_timing_pkg::OFF_SCAN_INTERVAL) begin
                next_s.rdata = {8'h00, s.scan_interval};
            end else if (addr_in == scan_timing_pkg::OFF_SAMPLE_INTERVAL) begin
                next_s.rdata = {16'h0000, s.sample_interval};
            end else if (addr_in == scan_timing_pkg::OFF_SCAN_TOTAL) begin
                next_s.rdata = {8'h00, s.scan_total};
            end else if (addr_in == scan_timing_pkg::OFF_CONV_PER_SCAN) begin
                next_s.rdata = {24'h000000, s.conv_per_scan};
            end else if (addr_in == scan_timing_pkg::OFF_STATUS) begin
                next_s.rdata[scan_timing_pkg::STAT_ACQ] = s.acq;
                next_s.rdata[scan_timing_pkg::STAT_SCAN] = s.scan;
                next_s.rdata[scan_timing_pkg::STAT_GATED] = gated_off;
                next_s.rdata[scan_timing_pkg::STAT_DONE_LSB +: 24] = s.scans_done;
            end
        end

        // Free-running timebase divider, rate chosen by software
        if (s.tb_cnt == 11'h000) begin
            next_s.tb_cnt = (s.ctrl[scan_timing_pkg::CTRL_TB_SLOW]
                ? scan_timing_pkg::TB_SLOW_DIV : scan_timing_pkg::TB_FAST_DIV)
                - 11'h001;
        end else begin
            next_s.tb_cnt = s.tb_cnt - 11'h001;
        end

        // trigger starts the sequence; counters loaded fresh
        if (!s.acq && (trig_ev.edge_hit || sw_trigger)) begin
            next_s.acq = 1'b1;
            next_s.si_cnt = s.scan_interval;
            next_s.scans_done = 24'h000000;
            next_s.gate_toggle = 1'b0;
            next_s.samp_cnt = s.sample_interval;
        end

        // scan interval counter runs only while acquiring
        if (s.acq && !s.ctrl[scan_timing_pkg::CTRL_SCAN_EXT] && si_tick) begin
            next_s.si_cnt = count_next(s.si_cnt, s.scan_interval);
        end

        // edge mode: each active gate edge during acquisition flips scan enable
        if (s.acq && gate_ev.edge_hit
            && route_of(s.route, scan_timing_pkg::ROUTE_GATE_LSB).edge_mode) begin
            next_s.gate_toggle = ~s.gate_toggle;
        end

        // scan begins, sample counter loaded and armed
        if (start_ok) begin
            next_s.scan = 1'b1;
            next_s.conv_left = s.conv_per_scan;
            next_s.samp_cnt = s.sample_interval;
            next_s.scan_pulse_cnt = scan_timing_pkg::PULSE_CYC;
            next_s.scan_level = 1'b1;
            next_s.off_cnt = 4'h0;
        end

        // sample counter counts down and reloads during the scan
        if (s.scan && !s.ctrl[scan_timing_pkg::CTRL_CONV_EXT] && tb_tick) begin
            next_s.samp_cnt = 16'(count_next({8'h00, s.samp_cnt},
                                             {8'h00, s.sample_interval}));
        end

        if (conv_fire) begin
            next_s.convert = 1'b1;
            next_s.conv_pulse_cnt = scan_timing_pkg::PULSE_CYC;
            next_s.conv_left = s.conv_left - 8'h01;
        end

        // scan ends on last conversion; counter reloaded for next
        if (last_conv) begin
            next_s.scan = 1'b0;
            next_s.samp_cnt = s.sample_interval;
            next_s.off_cnt = scan_timing_pkg::SCAN_OFF_CYC;
            next_s.scans_done = done_inc;
            // scan count reached ends the acquisition
            if ((s.scan_total != 24'h000000) && (done_inc == s.scan_total)) begin
                next_s.acq = 1'b0;
            end
        end

        if (s.scan_pulse_cnt != 4'h0) begin
            next_s.scan_pulse_cnt = s.scan_pulse_cnt - 4'h1;
        end

        if (s.conv_pulse_cnt != 4'h0) begin
            next_s.conv_pulse_cnt = s.conv_pulse_cnt - 4'h1;
        end

        // in-progress level falls a fixed delay after last conversion
        if (s.off_cnt != 4'h0) begin
            next_s.off_cnt = s.off_cnt - 4'h1;
            if (s.off_cnt == 4'h1) begin
                next_s.scan_level = 1'b0;
            end
        end

        // software stop aborts at once, a scan in flight included
        if (sw_stop) begin
            next_s.acq = 1'b0;
            next_s.scan = 1'b0;
            next_s.scan_level = 1'b0;
            next_s.off_cnt = 4'h0;
            next_s.samp_cnt = s.sample_interval;
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s <= '0;
            s.ctrl <= scan_timing_pkg::CTRL_RESET;
            s.scan_interval <= scan_timing_pkg::SCAN_INTERVAL_RESET;
            s.sample_interval <= scan_timing_pkg::SAMPLE_INTERVAL_RESET;
            s.scan_total <= scan_timing_pkg::SCAN_TOTAL_RESET;
            s.conv_per_scan <= scan_timing_pkg::CONV_PER_SCAN_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Pin outputs; output follows the accepted start, not the raw input
    always_comb begin
        programmable_function_pin_out = '0;
        programmable_function_pin_oe_out = '0;
        programmable_function_pin_out[scan_timing_pkg::PIN_SCAN_START] =
            s.ctrl[scan_timing_pkg::CTRL_SCAN_LEVEL_MODE]
            ? s.scan_level : (s.scan_pulse_cnt != 4'h0);
        programmable_function_pin_out[scan_timing_pkg::PIN_CONVERT] =
            (s.conv_pulse_cnt == 4'h0);
        // drivers off until software enables them
        programmable_function_pin_oe_out[scan_timing_pkg::PIN_SCAN_START] =
            s.ctrl[scan_timing_pkg::CTRL_SCAN_PIN_OE];
        programmable_function_pin_oe_out[scan_timing_pkg::PIN_CONVERT] =
            s.ctrl[scan_timing_pkg::CTRL_CONV_PIN_OE];
    end

    // Status and data outputs from flip-flops
    assign rdata_out = s.rdata;
    assign adc_convert_out = s.convert;
    assign acquisition_active_out = s.acq;
    assign scan_active_out = s.scan;

endmodule
`default_nettype wire

// >>> testbench/scan_timing_assertions.sv
// Port checker for the scan and conversion timing engine.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module scan_timing_assertions (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    input wire logic [31:0] rdata_out,
    // Pins and status
    input wire logic [scan_timing_pkg::NUM_PINS-1:0] programmable_function_pin_out,
    input wire logic [scan_timing_pkg::NUM_PINS-1:0] programmable_function_pin_oe_out,
    input wire logic adc_convert_out,
    input wire logic acquisition_active_out,
    input wire logic scan_active_out
);
    logic [7:0] ctrl;
    logic [3:0] since_conv;
    wire logic conv_pin = programmable_function_pin_out[2];
    wire logic scan_pin = programmable_function_pin_out[7];
    // Shadow of control and age of last conversion, saturating
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ctrl <= 8'h00;
            since_conv <= 4'hF;
        end else begin
            if (write_in && addr_in == 8'h00) begin
                ctrl <= wdata_in[7:0];
            end
            since_conv <= adc_convert_out ? 4'h1 : since_conv + 4'(since_conv != 4'hF);
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // Ten cycles active, then idle
    sequence conv_low_10;
        (!conv_pin)[*8] ##1 (!conv_pin)[*2] ##1 conv_pin;
    endsequence
    sequence scan_high_10;
        scan_pin[*8] ##1 scan_pin[*2] ##1 !scan_pin;
    endsequence
    AST_CONV_WIDTH: assert property ($fell(conv_pin) |-> conv_low_10)
        else $error("convert pin low time wrong");
    AST_CONV_MIRROR: assert property (adc_convert_out |-> $fell(conv_pin))
        else $error("convert pin does not follow conversion");
    AST_CONV_IN_SCAN: assert property (adc_convert_out |-> $past(scan_active_out))
        else $error("conversion outside a scan");
    AST_SCAN_IN_ACQ: assert property ($rose(scan_active_out) |-> $past(acquisition_active_out))
        else $error("scan outside acquisition");
    AST_SCAN_MIRROR: assert property ($rose(scan_active_out) |-> $rose(scan_pin))
        else $error("scan pin does not mark scan start");
    AST_SCAN_PULSE: assert property ($rose(scan_pin) && !ctrl[5] |-> scan_high_10)
        else $error("scan pulse width wrong");
    AST_SCAN_LEVEL_END: assert property ($fell(scan_pin) && ctrl[5]
        && acquisition_active_out |-> since_conv inside {[8:12]})
        else $error("scan level fell at wrong time");
    AST_OE_CTRL: assert property (programmable_function_pin_oe_out ==
        ((10'(ctrl[7]) << 2) | (10'(ctrl[6]) << 7)))
        else $error("pin enables differ from control");
    AST_RDATA_IDLE: assert property (!$past(read_in) |-> rdata_out == 32'h0)
        else $error("read data outside read slot");
    AST_READ_CTRL: assert property ($past(read_in) && $past(addr_in) == 8'h00
        |-> rdata_out == {24'h0, ctrl})
        else $error("control read back wrong");
endmodule
`default_nettype wire

// >>> testbench/pin_source.sv
// External trigger, strobe and gate source on the function pins.
// Assumes one caller at a time; pins are always driven.
`timescale 1ns/1ps
`default_nettype none
module pin_source (
    // Clock
    input wire logic clk_in,
    // Driven pins
    output logic [scan_timing_pkg::NUM_PINS-1:0] pins_out
);
    initial pins_out = 10'h000;
    // pulse, then a caller-chosen quiet gap
    task automatic pulse(input int pin, input int gap);
        @(posedge clk_in);
        pins_out[pin] <= ~pins_out[pin];
        repeat (5) @(posedge clk_in);
        pins_out[pin] <= ~pins_out[pin];
        repeat (gap) @(posedge clk_in);
    endtask
    // Idle or gate level
    task automatic set(input int pin, input logic v);
        @(posedge clk_in);
        pins_out[pin] <= v;
    endtask
endmodule
`default_nettype wire

// >>> testbench/scan_convert_timing_control_test.sv
// Bench for the scan timing engine: reset values, external pacing,
// gating, stop and internal pacing. Assumes the pin source model.
`timescale 1ns/1ps
`default_nettype none
module scan_convert_timing_control_test;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic write_in = 1'b0;
    logic read_in = 1'b0;
    logic [31:0] rdata_out;
    logic [9:0] programmable_function_pin_in;
    logic [9:0] programmable_function_pin_out;
    logic [9:0] programmable_function_pin_oe_out;
    logic adc_convert_out, acquisition_active_out, scan_active_out;
    int fails = 0, tests_run = 0, cyc = 0, scans = 0, convs = 0;
    typedef struct {logic [7:0] a; logic [31:0] v;} row_s;
    // Reset values, last row unmapped
    row_s rows[9] = '{'{8'h00, 32'h0}, '{8'h04, 32'h0}, '{8'h08, 32'h0},
        '{8'h0C, 32'hFF}, '{8'h10, 32'hF}, '{8'h14, 32'h0}, '{8'h18, 32'h1},
        '{8'h1C, 32'h0}, '{8'h24, 32'h0}};
    scan_convert_timing_control i_scan_convert_timing_control (.clk_in, .rst_b_in,
        .addr_in, .wdata_in, .write_in, .read_in, .rdata_out,
        .programmable_function_pin_in, .programmable_function_pin_out,
        .programmable_function_pin_oe_out, .adc_convert_out,
        .acquisition_active_out, .scan_active_out);
    pin_source i_pin_source (.clk_in, .pins_out(programmable_function_pin_in));
    initial forever #2.5 clk_in = ~clk_in;
    // Event counts, cumulative over the run
    always @(posedge scan_active_out) scans++;
    always @(posedge adc_convert_out) convs++;
    // Hang guard, well above run length
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        write_in <= 1'b1;
        @(posedge clk_in);
        write_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        read_in <= 1'b1;
        @(posedge clk_in);
        read_in <= 1'b0;
        @(negedge clk_in);
        check(rdata_out, exp);
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(negedge clk_in);
        check(programmable_function_pin_oe_out, 10'h000);
        check(programmable_function_pin_out, 10'h004);
        foreach (rows[i]) rd(rows[i].a, rows[i].v);
        $display("test reset values done");
        // Scan on pin 3 rising, strobe on pin 4 falling, gate on pin 5 level
        i_pin_source.set(4, 1'b1);
        wr(8'h04, 32'h0005_1403);
        wr(8'h00, 32'hC6);
        i_pin_source.pulse(4, 20);
        i_pin_source.pulse(3, 20);
        check(32'(scans + convs), 32'h0);
        wr(8'h20, 32'h1);
        repeat (3) @(posedge clk_in);
        check(acquisition_active_out, 1'b1);
        i_pin_source.pulse(3, 20);
        check(32'(scans), 32'h1);
        check(scan_active_out, 1'b1);
        i_pin_source.pulse(4, 20);
        i_pin_source.pulse(4, 20);
        check(32'(convs), 32'h1);
        $display("test external pacing done");
        i_pin_source.set(5, 1'b1);
        i_pin_source.pulse(3, 20);
        i_pin_source.set(5, 1'b0);
        wr(8'h00, 32'hC7);
        i_pin_source.pulse(3, 20);
        wr(8'h00, 32'hC6);
        check(32'(scans), 32'h1);
        wr(8'h04, 32'h0625_1403);
        i_pin_source.pulse(5, 20);
        i_pin_source.pulse(3, 20);
        check(32'(scans), 32'h1);
        i_pin_source.pulse(5, 20);
        i_pin_source.pulse(3, 20);
        i_pin_source.pulse(4, 20);
        check(32'(scans), 32'h2);
        check(32'(convs), 32'h2);
        wr(8'h20, 32'h2);
        repeat (3) @(posedge clk_in);
        check(acquisition_active_out, 1'b0);
        $display("test gating and stop done");
        // Internal: scan every 100 cycles, two conversions 20 apart
        wr(8'h0C, 32'h9);
        wr(8'h10, 32'h1);
        wr(8'h18, 32'h2);
        wr(8'h00, 32'hE0);
        rd(8'h00, 32'hE0);
        wr(8'h20, 32'h1);
        repeat (250) @(posedge clk_in);
        check(32'(scans), 32'h4);
        check(32'(convs), 32'h6);
        wr(8'h00, 32'hE8);
        repeat (10) i_pin_source.pulse(6, 5);
        check(32'(scans), 32'h5);
        wr(8'h20, 32'h2);
        $display("test internal pacing done");
        stop_test();
    end
endmodule
bind scan_convert_timing_control scan_timing_assertions i_scan_timing_assertions (.clk_in,
    .rst_b_in, .addr_in, .wdata_in, .write_in, .read_in, .rdata_out,
    .programmable_function_pin_out, .programmable_function_pin_oe_out,
    .adc_convert_out, .acquisition_active_out, .scan_active_out);
`default_nettype wire
